// ===== blw_defs.svh
/*
  constants for the lockout / waiting state machine: register offsets, field positions,
  reset values and timing counts.
  assumes inclusion by bare name from the state machine, the monitor and the bench.
*/
`ifndef BLW_DEFS_SVH
`define BLW_DEFS_SVH

// register byte offsets
`define BLW_CTRL_OFS      12'h000
`define BLW_CFG_OFS       12'h004
`define BLW_COND_OFS      12'h008
`define BLW_STAT_OFS      12'h00C
`define BLW_LOCK_OFS      12'h010
// control bits (write one, self clearing)
`define BLW_CTRL_START    0
`define BLW_CTRL_STOP     1
`define BLW_CTRL_ACK      2
// config fields
`define BLW_CFG_LVR       0
`define BLW_CFG_POM_LSB   1
`define BLW_CFG_RELIGHT_LSB 4
`define BLW_CFG_RESET     32'h0000_0000
// pilot off mode encodings
`define BLW_POM_OFF_AFTER_MAIN 2'h1
`define BLW_POM_FOLLOW_MAIN    2'h2
// failures before lockout
`define BLW_IGN_FAIL_MAX  2'h3
// position error timeout, microseconds
`define BLW_POS_TMO_US    1000
`define BLW_CLK_MHZ       25
// edges held in power on after reset release, so synchronised inputs are valid
`define BLW_ARM_LAST      2'h3
`define BLW_POS_TMO_CYC   (`BLW_POS_TMO_US * `BLW_CLK_MHZ)
`endif

// ===== blw_field_model.sv
/*
  field side model: sensors, proofs, operator conditions and power-down straps.
  assumes its tasks are called just after a rising clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module blw_field_model
  import blw_pkg::*;
(
  input  wire logic       i_sys_clk,
  output var  blw_cond_s  o_cond,
  output var  logic [1:0] o_pp_sub,
  output var  logic       o_was_running,
  output var  logic       o_lock_retained
);
  // positions and airflow proven, no flame: a healthy idle burner
  initial begin
    o_cond          = blw_cond_s'(9'h03C);
    o_pp_sub        = BLW_PP_OTHER;
    o_was_running   = 1'b0;
    o_lock_retained = 1'b0;
  end

  task automatic set_cond(input logic alarm, input logic waitc);
    o_cond.alarm     <= alarm;
    o_cond.wait_cond <= waitc;
  endtask

  // straps only change while the controller is held in reset
  task automatic set_straps(input logic was, input logic lock);
    o_was_running   <= was;
    o_lock_retained <= lock;
  endtask
endmodule // blw_field_model
`default_nettype wire

// ===== blw_fsm.sv
/*
  master state machine: entry to and exit from lockout, entry to waiting, safety outputs
  and purge events, with an apb slave for commands, settings and status.
  assumes field inputs are asynchronous and the retained power-down flags are static
  straps that are stable at reset release.
*/
// The register offsets and the APB slave port were left to the implementer.
// What this block does
// - alarm in any running state forces lockout
// - power on goes to lockout if a retained lockout is unacknowledged
// - lockout holds all safety outputs off and purges once on entry
// - pre-purge locks out on unproven purge position outside request-pilot
// - pre-purge locks out on unproven airflow in prove-airflow or purge
// - pre-purge locks out on unproven pilot position in request-pilot
// - third consecutive pilot ignition failure causes lockout
// - flame loss past relight limit in fuel states causes lockout
// - flame already present on entering ignition causes lockout
// - light-off position unproven after position timeout in pilot causes lockout
// - waiting entered on user start from ready or wait condition
// - waiting is running with all safety outputs off
// - purge on entering waiting from fuel state only
// - power on restarts into waiting when running, restart enabled, clean
// - ignition failure below three returns to waiting
// - flame loss within relight limit in ignition or pilot returns to waiting
// - main permissive with pilot-off mode off-after-main or follow returns to waiting
// - acknowledge leaves lockout for ready, then alarm if still present
`timescale 1ns/1ps
`default_nettype none
`include "blw_defs.svh"
module blw_fsm
  import blw_pkg::*;
#(
  parameter int unsigned POS_TMO_CYC = `BLW_POS_TMO_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire blw_cond_s   i_cond,
  input  wire logic [1:0]  i_pp_sub,
  input  wire logic        i_was_running,
  input  wire logic        i_lock_retained,
  output blw_out_s         o_safety,
  output logic             o_purge,
  output logic [3:0]       o_state
);
  ////////////////////////////////////////////////////////////////////////////
  // synchronised field inputs
  blw_cond_s   cond;
  logic [1:0]  pp_raw;
  blw_pp_sub_e pp_sub;

  blw_sync #(.W($bits(blw_cond_s) + 2)) blw_sync_inst (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_cond, i_pp_sub}),
    .o_sync    ({cond, pp_raw})
  );
  assign pp_sub = blw_pp_sub_e'(pp_raw);

  ////////////////////////////////////////////////////////////////////////////
  // state declarations
  blw_state_e state_q, state_d;
  blw_state_e prev_q, prev_d;
  logic [1:0] fail_q, fail_d;
  logic [3:0] relight_q, relight_d;
  logic       lock_msg_q, lock_msg_d;
  logic       strap_q, strap_d;
  logic       was_run_q, was_run_d;
  logic       purge_q, purge_d;
  logic       flame_prev_q, flame_prev_d;
  blw_out_s   safety_q, safety_d;
  logic [3:0] state_out_q, state_out_d;
  logic       start_q, start_d;
  logic       stop_q, stop_d;
  logic       ack_q, ack_d;
  logic [31:0] cfg_q, cfg_d;
  logic [31:0] rdata_q, rdata_d;
  logic        rdy_q, rdy_d;
  logic        err_q, err_d;
  logic        pos_tmo;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, reads registered
  logic       lvr_en;
  logic [1:0] pom;
  logic [3:0] relight_max;
  logic       apb_acc;
  logic       apb_wr;

  assign lvr_en      = cfg_q[`BLW_CFG_LVR];
  assign pom         = cfg_q[`BLW_CFG_POM_LSB +: 2];
  assign relight_max = cfg_q[`BLW_CFG_RELIGHT_LSB +: 4];
  assign apb_acc     = psel && penable && !rdy_q;
  assign apb_wr      = apb_acc && pwrite;

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = 32'h0000_0000;
    rdy_d   = apb_acc;
    err_d   = 1'b0;
    start_d = 1'b0;
    stop_d  = 1'b0;
    ack_d   = 1'b0;
    if (apb_acc) begin
      unique case (paddr)
        `BLW_CTRL_OFS: begin
          if (pwrite) begin
            start_d = pwdata[`BLW_CTRL_START];
            stop_d  = pwdata[`BLW_CTRL_STOP];
            ack_d   = pwdata[`BLW_CTRL_ACK];
          end
        end
        `BLW_CFG_OFS: begin
          if (pwrite) begin
            cfg_d = {25'h0000000, pwdata[6:0]};
          end else begin
            rdata_d = cfg_q;
          end
        end
        `BLW_COND_OFS: rdata_d = {23'h000000, cond};
        `BLW_STAT_OFS: rdata_d = {20'h00000, fail_q, relight_q, was_run_q, purge_q,
                                  state_q};
        `BLW_LOCK_OFS: rdata_d = {31'h00000000, lock_msg_q};
        default:       err_d   = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q   <= `BLW_CFG_RESET;
      rdata_q <= 32'h0000_0000;
      rdy_q   <= 1'b0;
      err_q   <= 1'b0;
      start_q <= 1'b0;
      stop_q  <= 1'b0;
      ack_q   <= 1'b0;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
      rdy_q   <= rdy_d;
      err_q   <= err_d;
      start_q <= start_d;
      stop_q  <= stop_d;
      ack_q   <= ack_d;
    end
  end
  assign prdata  = rdata_q;
  assign pready  = rdy_q;
  assign pslverr = err_q;

  ////////////////////////////////////////////////////////////////////////////
  // position error timer, runs while pilot waits for light-off position
  blw_timer #(.LIMIT(POS_TMO_CYC)) blw_timer_inst (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_run     ((state_q == BLW_PILOT) && !cond.lightoff_pos),
    .o_done    (pos_tmo)
  );

  ////////////////////////////////////////////////////////////////////////////
  // master state machine
  function automatic logic is_running(input blw_state_e s);
    is_running = (s == BLW_WAITING) || (s == BLW_STARTUP) || (s == BLW_PREPURGE) ||
                 is_fuel(s);
  endfunction

  function automatic logic is_fuel(input blw_state_e s);
    is_fuel = (s == BLW_IGNITION) || (s == BLW_PILOT) || (s == BLW_LOW_FIRE) ||
              (s == BLW_PROCESS);
  endfunction

  logic lock_go;
  logic wait_go;
  logic flame_loss;
  logic relight_over;
  logic pom_main;

  always_comb begin
    state_d      = state_q;
    prev_d       = state_q;
    fail_d       = fail_q;
    relight_d    = relight_q;
    lock_msg_d   = lock_msg_q;
    strap_d      = strap_q;
    was_run_d    = was_run_q;
    flame_prev_d = cond.flame;
    lock_go      = 1'b0;
    wait_go      = 1'b0;
    flame_loss   = flame_prev_q && !cond.flame;
    relight_over = relight_q >= relight_max;
    pom_main     = (pom == `BLW_POM_OFF_AFTER_MAIN) || (pom == `BLW_POM_FOLLOW_MAIN);

    if (is_running(state_q)) begin
      lock_go = cond.alarm || stop_q;
    end
    unique case (state_q)
      BLW_POWER_ON: begin
        if (strap_q) begin
          lock_go = 1'b1;
        end else if (cond.alarm) begin
          state_d = BLW_READY;
        end else if (was_run_q && lvr_en) begin
          wait_go = 1'b1;
        end else begin
          state_d = BLW_READY;
        end
      end
      BLW_READY: begin
        if (cond.alarm) begin
          state_d = BLW_ALARM;
        end else if (start_q) begin
          wait_go = 1'b1;
        end
      end
      BLW_WAITING: begin
        state_d = BLW_WAITING;
      end
      BLW_ALARM: begin
        if (!cond.alarm) begin
          state_d = BLW_READY;
        end
      end
      BLW_LOCKOUT: begin
        if (ack_q) begin
          state_d    = BLW_READY;
          lock_msg_d = 1'b0;
        end
      end
      BLW_STARTUP: begin
        if (cond.airflow) begin
          lock_go = 1'b1;
        end
        wait_go = cond.wait_cond;
      end
      BLW_PREPURGE: begin
        if (!cond.purge_pos && (pp_sub != BLW_PP_REQ_PILOT)) begin
          lock_go = 1'b1;
        end
        if (!cond.airflow && ((pp_sub == BLW_PP_PROVE_AIR) || (pp_sub == BLW_PP_PURGE))) begin
          lock_go = 1'b1;
        end
        if (!cond.pilot_pos && (pp_sub == BLW_PP_REQ_PILOT)) begin
          lock_go = 1'b1;
        end
        wait_go = cond.wait_cond;
      end
      BLW_IGNITION: begin
        if ((prev_q != BLW_IGNITION) && cond.flame) begin
          lock_go = 1'b1;
        end
        if (cond.ign_fail) begin
          fail_d = fail_q + 2'h1;
          if (fail_q + 2'h1 >= `BLW_IGN_FAIL_MAX) begin
            lock_go = 1'b1;
          end else begin
            wait_go = 1'b1;
          end
        end
        if (flame_loss) begin
          relight_d = relight_q + 4'h1;
          if (relight_over) begin
            lock_go = 1'b1;
          end else begin
            wait_go = 1'b1;
          end
        end
        if (cond.flame && !cond.ign_fail && (prev_q == BLW_IGNITION)) begin
          fail_d = 2'h0;
        end
      end
      BLW_PILOT: begin
        if (pos_tmo) begin
          lock_go = 1'b1;
        end
        if (flame_loss) begin
          relight_d = relight_q + 4'h1;
          if (relight_over) begin
            lock_go = 1'b1;
          end else begin
            wait_go = 1'b1;
          end
        end
        if (cond.wait_cond || (cond.main_perm && pom_main)) begin
          wait_go = 1'b1;
        end
      end
      BLW_LOW_FIRE, BLW_PROCESS: begin
        if (flame_loss && relight_over) begin
          lock_go = 1'b1;
        end else if (flame_loss) begin
          relight_d = relight_q + 4'h1;
          wait_go   = 1'b1;
        end
        if (cond.wait_cond || (cond.main_perm && pom_main)) begin
          wait_go = 1'b1;
        end
      end
      default: begin
        lock_go = 1'b1;
      end
    endcase

    if (lock_go) begin
      state_d    = BLW_LOCKOUT;
      lock_msg_d = 1'b1;
    end else if (wait_go) begin
      state_d = BLW_WAITING;
    end
    if (state_q == BLW_READY && state_d == BLW_WAITING) begin
      relight_d = 4'h0;
    end
    strap_d   = (state_q == BLW_POWER_ON) ? 1'b0 : strap_q;
    was_run_d = (state_q == BLW_POWER_ON) ? 1'b0 : was_run_q;
  end

  // outputs: fuel paths off in every state, fuel states included
  always_comb begin
    purge_d     = 1'b0;
    safety_d    = '0;
    state_out_d = state_d;
    if ((state_d == BLW_LOCKOUT) && (state_q != BLW_LOCKOUT)) begin
      purge_d = 1'b1;
    end
    if ((state_d == BLW_WAITING) && (state_q != BLW_WAITING) && is_fuel(state_q)) begin
      purge_d = 1'b1;
    end
    // every state is de-energised; nothing else drives o_safety, so it stays all zero
    safety_d.ign_enable = 1'b0;
  end

  // straps caught after reset release; the power-on decision waits until the
  // synchronisers hold real field values, so an alarm at power up is not missed
  logic [1:0] arm_q;
  logic [1:0] arm_d;
  assign arm_d = (arm_q == `BLW_ARM_LAST) ? arm_q : arm_q + 2'h1;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      arm_q <= 2'h0;
    end else begin
      arm_q <= arm_d;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q      <= BLW_POWER_ON;
      prev_q       <= BLW_POWER_ON;
      fail_q       <= 2'h0;
      relight_q    <= 4'h0;
      lock_msg_q   <= 1'b0;
      strap_q      <= 1'b0;
      was_run_q    <= 1'b0;
      flame_prev_q <= 1'b0;
      purge_q      <= 1'b0;
      safety_q     <= '0;
      state_out_q  <= 4'h0;
    end else if (arm_q != `BLW_ARM_LAST) begin
      strap_q    <= i_lock_retained;
      was_run_q  <= i_was_running;
      lock_msg_q <= i_lock_retained;
    end else begin
      state_q      <= state_d;
      prev_q       <= prev_d;
      fail_q       <= fail_d;
      relight_q    <= relight_d;
      lock_msg_q   <= lock_msg_d;
      strap_q      <= strap_d;
      was_run_q    <= was_run_d;
      flame_prev_q <= flame_prev_d;
      purge_q      <= purge_d;
      safety_q     <= safety_d;
      state_out_q  <= state_out_d;
    end
  end

  assign o_safety = safety_q;
  assign o_purge  = purge_q;
  assign o_state  = state_out_q;
endmodule // blw_fsm
`default_nettype wire

// ===== blw_fsm_monitor.sv
/*
  concurrent checks on the lockout / waiting state machine, seen from its ports only.
  assumes blw_pkg and blw_defs.svh are available and o_purge lines up with o_state.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blw_defs.svh"
module blw_fsm_monitor
  import blw_pkg::*;
#(
  parameter int unsigned POS_TMO_CYC = `BLW_POS_TMO_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic        pready,
  input  wire blw_cond_s   i_cond,
  input  wire logic        i_lock_retained,
  input  wire blw_out_s    o_safety,
  input  wire logic        o_purge,
  input  wire logic [3:0]  o_state
);
  logic       ctrl_wr;
  logic [2:0] ack_hist_d;
  logic [2:0] ack_hist_q;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  // an acknowledge may take a few edges to act, so keep a short history of it
  assign ctrl_wr    = psel && penable && pready && pwrite && (paddr == `BLW_CTRL_OFS);
  assign ack_hist_d = {ack_hist_q[1:0], ctrl_wr && pwdata[`BLW_CTRL_ACK]};
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ack_hist_q <= 3'h0;
    end else begin
      ack_hist_q <= ack_hist_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  AST_SAFE_OFF: assert property (o_safety == '0)
    else $error("safety output energized");
  AST_LOCK_PURGE: assert property
    (o_state == BLW_LOCKOUT && $past(o_state) != BLW_LOCKOUT |-> o_purge)
    else $error("no purge on lockout entry");
  AST_PURGE_ONE: assert property (o_purge |=> !o_purge)
    else $error("purge pulse longer than one cycle");
  AST_WAIT_NOPURGE: assert property
    (o_state == BLW_WAITING && $past(o_state) inside {BLW_POWER_ON, BLW_READY} |-> !o_purge)
    else $error("purge on entry to waiting from non-fuel state");
  AST_PURGE_CAUSE: assert property
    (o_purge |-> (o_state == BLW_LOCKOUT && $past(o_state) != BLW_LOCKOUT) ||
      (o_state == BLW_WAITING &&
       $past(o_state) inside {BLW_IGNITION, BLW_PILOT, BLW_LOW_FIRE, BLW_PROCESS}))
    else $error("purge without a qualifying entry");
  AST_ALARM_LOCK: assert property
    ($rose(i_cond.alarm) && o_state == BLW_WAITING |-> ##[1:6] o_state == BLW_LOCKOUT)
    else $error("alarm while waiting did not lock out");
  AST_ACK_READY: assert property
    (o_state == BLW_LOCKOUT ##1 o_state != BLW_LOCKOUT |-> o_state == BLW_READY && |ack_hist_q)
    else $error("lockout left without acknowledge or not to ready");
  AST_ACK_ALARM: assert property
    (o_state == BLW_LOCKOUT ##1 (o_state == BLW_READY && i_cond.alarm)
      |-> ##[1:4] o_state == BLW_ALARM)
    else $error("acknowledge with alarm present did not reach alarm");
  AST_START_WAIT: assert property
    (ctrl_wr && pwdata[`BLW_CTRL_START] && o_state == BLW_READY && !i_cond.alarm
      |-> ##[1:3] o_state == BLW_WAITING)
    else $error("start from ready did not reach waiting");
  AST_POWER_LOCK: assert property
    (o_state != BLW_POWER_ON && $past(o_state) == BLW_POWER_ON && i_lock_retained
      |-> o_state == BLW_LOCKOUT)
    else $error("retained lockout not restored at power on");
endmodule // blw_fsm_monitor

bind blw_fsm blw_fsm_monitor #(.POS_TMO_CYC(POS_TMO_CYC)) blw_fsm_monitor_inst (
  .i_sys_clk, .i_resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .i_cond, .i_lock_retained, .o_safety, .o_purge, .o_state
);
`default_nettype wire

// ===== blw_pkg.sv
/*
  types shared by the lockout / waiting state machine files.
  assumes blw_defs.svh on the include path.
*/
package blw_pkg;
  typedef enum logic [3:0] {
    BLW_POWER_ON  = 4'h0,
    BLW_READY     = 4'h1,
    BLW_WAITING   = 4'h3,
    BLW_STARTUP   = 4'h2,
    BLW_PREPURGE  = 4'h6,
    BLW_IGNITION  = 4'h7,
    BLW_PILOT     = 4'h5,
    BLW_LOW_FIRE  = 4'h4,
    BLW_PROCESS   = 4'hC,
    BLW_ALARM     = 4'hD,
    BLW_LOCKOUT   = 4'h8
  } blw_state_e;

  typedef enum logic [1:0] {
    BLW_PP_PROVE_AIR = 2'h0,
    BLW_PP_PURGE     = 2'h1,
    BLW_PP_REQ_PILOT = 2'h3,
    BLW_PP_OTHER     = 2'h2
  } blw_pp_sub_e;

  // field condition inputs, all synchronised before use
  typedef struct packed {
    logic alarm;
    logic wait_cond;
    logic main_perm;
    logic purge_pos;
    logic airflow;
    logic pilot_pos;
    logic lightoff_pos;
    logic flame;
    logic ign_fail;
  } blw_cond_s;

  typedef struct packed {
    logic pilot;
    logic shutoff_valve_first;
    logic shutoff_valve_second;
    logic valve;
    logic coil;
    logic ign_enable;
  } blw_out_s;
endpackage

// ===== blw_sync.sv
/*
  two flip-flop synchroniser, one per bit of a vector.
  assumes the input is asynchronous to i_sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module blw_sync #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_resetn,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule // blw_sync
`default_nettype wire

// ===== blw_timer.sv
/*
  up counter that reports when a preset count has elapsed while enabled.
  assumes a synchronous enable from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module blw_timer #(
  parameter int unsigned LIMIT = 25000
) (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_run,
  output logic      o_done
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        done_q;
  logic        done_d;

  always_comb begin
    cnt_d  = cnt_q;
    done_d = 1'b0;
    if (!i_run) begin
      cnt_d = 32'h0000_0000;
    end else if (cnt_q >= 32'(LIMIT - 1)) begin
      done_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= 32'h0000_0000;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end
  assign o_done = done_q;
endmodule // blw_timer
`default_nettype wire

// ===== tb_burner_lockout_wait_fsm.sv
/*
  self-checking bench for blw_fsm: power-on, start, alarm, stop and acknowledge paths.
  assumes the field model and the bound monitor are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "blw_defs.svh"
module tb_burner_lockout_wait_fsm
  import blw_pkg::*;
();
  logic        sys_clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  blw_cond_s   cond;
  logic [1:0]  pp_sub;
  logic        was_running;
  logic        lock_retained;
  blw_out_s    safety;
  logic        purge;
  logic [3:0]  state;
  int          err_count = 0;
  int          n_tests = 0;
  int          purge_cnt = 0;

  blw_fsm #(.POS_TMO_CYC(10)) blw_fsm_inst (
    .i_sys_clk(sys_clk), .i_resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_cond(cond), .i_pp_sub(pp_sub), .i_was_running(was_running),
    .i_lock_retained(lock_retained), .o_safety(safety), .o_purge(purge), .o_state(state)
  );
  blw_field_model blw_field_model_inst (
    .i_sys_clk(sys_clk), .o_cond(cond), .o_pp_sub(pp_sub),
    .o_was_running(was_running), .o_lock_retained(lock_retained)
  );

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (purge === 1'b1) begin
      purge_cnt++;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    if (err_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd_data, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", {31'h0, pready}, 32'h1);
    rd_data = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk("pslverr", {31'h0, e}, {31'h0, exp_err});
    if (exp_err == 1'b0) begin
      chk("prdata", d, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, v, d, e);
    chk("pslverr", {31'h0, e}, 32'h0);
  endtask

  task automatic cmd(input int b);
    wr(`BLW_CTRL_OFS, 32'h1 << b);
  endtask

  // samples on the falling edge so the state register has settled
  task automatic wait_state(input blw_state_e exp);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (state !== exp && n < 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk("state", {28'h0, state}, {28'h0, exp});
    @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic was, input logic lock);
    resetn <= 1'b0;
    blw_field_model_inst.set_straps(was, lock);
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask

  task automatic chk_purge(input int p0, input int exp);
    repeat (2) @(posedge sys_clk);
    chk("purge count", 32'(purge_cnt - p0), 32'(exp));
    chk("safety", {26'h0, safety}, 32'h0);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic sc_power_lock();
    int p0;
    do_reset(1'b0, 1'b1);
    p0 = purge_cnt;
    wait_state(BLW_LOCKOUT);
    chk_purge(p0, 1);
    rd(`BLW_LOCK_OFS, 32'h1, 1'b0);
    cmd(`BLW_CTRL_ACK);
    wait_state(BLW_READY);
    rd(`BLW_LOCK_OFS, 32'h0, 1'b0);
  endtask

  task automatic sc_power_ready();
    do_reset(1'b1, 1'b0);
    wait_state(BLW_READY);
    rd(`BLW_COND_OFS, 32'h0000_003C, 1'b0);
    rd(`BLW_STAT_OFS, 32'h0000_0001, 1'b0);
    rd(`BLW_CFG_OFS, `BLW_CFG_RESET, 1'b0);
    wr(`BLW_CFG_OFS, 32'hFFFF_FFFF);
    rd(`BLW_CFG_OFS, 32'h0000_007F, 1'b0);
    wr(`BLW_CFG_OFS, 32'h0);
    rd(`BLW_CTRL_OFS, 32'h0, 1'b0);
    rd(12'h020, 32'h0, 1'b1);
  endtask

  // restart enabled right after release, before the power-on decision is taken
  task automatic sc_power_wait();
    int p0;
    do_reset(1'b1, 1'b0);
    p0 = purge_cnt;
    wr(`BLW_CFG_OFS, 32'h1 << `BLW_CFG_LVR);
    wait_state(BLW_WAITING);
    chk_purge(p0, 0);
    cmd(`BLW_CTRL_STOP);
    wait_state(BLW_LOCKOUT);
    cmd(`BLW_CTRL_ACK);
    wait_state(BLW_READY);
  endtask

  task automatic sc_start_wait();
    int p0;
    p0 = purge_cnt;
    cmd(`BLW_CTRL_START);
    wait_state(BLW_WAITING);
    chk_purge(p0, 0);
  endtask

  // alarm and wait condition together: lockout must win
  task automatic sc_alarm_lock();
    int p0;
    p0 = purge_cnt;
    blw_field_model_inst.set_cond(1'b1, 1'b1);
    wait_state(BLW_LOCKOUT);
    chk_purge(p0, 1);
    cmd(`BLW_CTRL_ACK);
    wait_state(BLW_ALARM);
    blw_field_model_inst.set_cond(1'b0, 1'b0);
    wait_state(BLW_READY);
  endtask

  task automatic sc_stop();
    int p0;
    cmd(`BLW_CTRL_START);
    wait_state(BLW_WAITING);
    p0 = purge_cnt;
    cmd(`BLW_CTRL_STOP);
    wait_state(BLW_LOCKOUT);
    chk_purge(p0, 1);
    cmd(`BLW_CTRL_ACK);
    wait_state(BLW_READY);
  endtask

  initial begin
    resetn  = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
    sc_power_lock();
    sc_power_ready();
    sc_power_wait();
    sc_start_wait();
    sc_alarm_lock();
    sc_stop();
    results();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    results();
  end
endmodule // tb_burner_lockout_wait_fsm
`default_nettype wire
